//--- verilog/cpoc_consts.svh
// Constants for the compare PWM output channel
`ifndef CPOC_CONSTS_SVH
`define CPOC_CONSTS_SVH
`define CPOC_DIR_OUTPUT 2'h0
`define CPOC_MODE_FROZEN 3'h0
`define CPOC_MODE_SET_ACT 3'h1
`define CPOC_MODE_SET_INACT 3'h2
`define CPOC_MODE_TOGGLE 3'h3
`define CPOC_MODE_FORCE_LO 3'h4
`define CPOC_MODE_FORCE_HI 3'h5
`define CPOC_MODE_PWM1 3'h6
`define CPOC_MODE_PWM2 3'h7
`define CPOC_CMS_EDGE 2'h0
`define CPOC_CMS_DOWN 2'h1
`define CPOC_CMS_UP 2'h2
`define CPOC_CMS_BOTH 2'h3
`define CPOC_TRIG_SEL_INPUT 3'h6
`define CPOC_SLAVE_TRIGGER 3'h6
`define CPOC_RESET_WORD 16'h0000
`endif

//--- verilog/cpoc_pkg.sv
// Types for the compare PWM output channel
package cpoc_pkg;
  typedef enum logic [2:0] {
    CPOC_FROZEN, CPOC_SET_ACT, CPOC_SET_INACT, CPOC_TOGGLE,
    CPOC_FORCE_LO, CPOC_FORCE_HI, CPOC_PWM1, CPOC_PWM2
  } cpoc_mode_t;
  typedef struct packed {
    logic [1:0] channelDirectionSelect;
    logic [2:0] compareModeField;
    logic comparePreloadEnable;
    logic fastOutputEnable;
    logic outputPolarity;
    logic channelOutputEnable;
    logic channelIrqEnable;
  } cpoc_chan_cfg_t;
  typedef struct packed {
    logic [1:0] centerAlignSelect;
    logic singlePulseEnable;
    logic reloadPreloadEnable;
    logic [2:0] triggerSourceSelect;
    logic [2:0] slaveModeSelect;
  } cpoc_cnt_cfg_t;
endpackage

//--- verilog/cpoc_counter.sv
// Up/down counter with auto-reload shadow, one-pulse stop and trigger start
`timescale 1ns/1ps
`include "cpoc_consts.svh"
module cpoc_counter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire cpoc_pkg::cpoc_cnt_cfg_t cntCfg,
  input wire logic dirSw,
  input wire logic [15:0] autoReloadWrite,
  input wire logic autoReloadWrEn,
  input wire logic counterRunSet,
  input wire logic counterRunClr,
  input wire logic updateGenerate,
  input wire logic triggerStart,
  output logic [15:0] counterValue,
  output logic [15:0] autoReloadValue,
  output logic countDown,
  output logic counterRun,
  output logic updateEvent
);
  import cpoc_pkg::*;
  logic [15:0] cnt_q, cnt_d, arrPre_q, arrShadow_q;
  logic dir_q, dir_d, run_q, run_d;
  wire logic edgeMode = (cntCfg.centerAlignSelect == `CPOC_CMS_EDGE);
  wire logic atTop = (cnt_q == arrShadow_q);
  wire logic atZero = (cnt_q == `CPOC_RESET_WORD);
  // Center-aligned turns one count early, so its period ends where it turns
  wire logic turnDown = !dir_q && (cnt_q + 16'h0001 >= arrShadow_q);
  wire logic turnUp = dir_q && (cnt_q <= 16'h0001);
  // Overflow/underflow marks the period end
  wire logic rollOver = run_q && (edgeMode ? (dir_q ? atZero : atTop) : (turnDown || turnUp));
  wire logic update_event = rollOver || updateGenerate;
  wire logic [15:0] arrNext = autoReloadWrEn ? autoReloadWrite : arrPre_q;

  always_comb begin
    cnt_d = cnt_q;
    dir_d = edgeMode ? dirSw : dir_q;
    run_d = run_q;
    if (updateGenerate) begin
      cnt_d = dir_d && edgeMode ? arrShadow_q : `CPOC_RESET_WORD;
      // Restart from zero must count up, or the first step would wrap below zero
      if (!edgeMode) begin
        dir_d = 1'b0;
      end
    end else if (run_q) begin
      if (edgeMode) begin
        if (dir_q) begin
          cnt_d = atZero ? arrShadow_q : cnt_q - 16'h0001;
        end else begin
          cnt_d = atTop ? `CPOC_RESET_WORD : cnt_q + 16'h0001;
        end
      end else begin
        // Center-aligned: hardware owns the direction bit
        if (turnDown) begin
          dir_d = 1'b1;
        end else if (turnUp) begin
          dir_d = 1'b0;
        end
        cnt_d = dir_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end
    end
    if (counterRunSet || (triggerStart &&
        cntCfg.triggerSourceSelect == `CPOC_TRIG_SEL_INPUT &&
        cntCfg.slaveModeSelect == `CPOC_SLAVE_TRIGGER)) begin
      run_d = 1'b1;
    end
    if (counterRunClr || (rollOver && cntCfg.singlePulseEnable)) begin
      run_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= `CPOC_RESET_WORD;
      dir_q <= 1'b0;
      run_q <= 1'b0;
      arrPre_q <= 16'hFFFF;
      arrShadow_q <= 16'hFFFF;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      run_q <= run_d;
      arrPre_q <= arrNext;
      if (!cntCfg.reloadPreloadEnable || update_event) begin
        arrShadow_q <= arrNext;
      end
    end
  end

  assign counterValue = cnt_q;
  assign autoReloadValue = arrShadow_q;
  assign countDown = dir_q;
  assign counterRun = run_q;
  assign updateEvent = update_event;
endmodule

//--- verilog/cpoc_channel.sv
// Compare PWM output channel: compare, PWM, one-pulse and pin stage
`timescale 1ns/1ps
`include "cpoc_consts.svh"
// Function
// - Output behaviour only when direction selects output
// - Mode 101 forces reference high
// - Mode 100 forces reference low
// - Pin equals reference, inverted by polarity
// - Forced modes still compare and flag
// - Match actions: keep, active, inactive, toggle
// - Match sets flag, irq when enabled
// - Preload clear writes direct, else update
// - Update event never moves compare output
// - Modes 110 and 111 select PWM
// - Update generate copies all preloads; compare waits while an upper byte is pending
// - PWM1 up: high below compare
// - PWM1 down: low above compare
// - Edge mode direction bit sets count direction
// - Center field selects flag direction
// - Center mode direction owned by hardware
// - One-pulse clears run at the period end, not on update generate
// - Pulse delay compare, width reload minus compare plus one
// - Trigger edge sets counter run
// - Fast enable applies match level on trigger
// - Upper byte write blocks shadow until lower
module cpoc_channel (
  input wire logic clk_sys,
  input wire logic rst,
  input wire cpoc_pkg::cpoc_chan_cfg_t chanCfg,
  input wire cpoc_pkg::cpoc_cnt_cfg_t cntCfg,
  input wire logic dirSw,
  input wire logic [7:0] compareByteData,
  input wire logic compareHighWrite,
  input wire logic compareLowWrite,
  input wire logic [15:0] autoReloadWrite,
  input wire logic autoReloadWrEn,
  input wire logic counterRunSet,
  input wire logic counterRunClr,
  input wire logic updateGenerate,
  input wire logic timerInputPin,
  input wire logic mainOutputGate,
  input wire logic matchFlagClear,
  output logic channelPinOutput,
  output logic channelPinOutputEn,
  output logic outputReference,
  output logic channelMatchFlag,
  output logic channelIrq,
  output logic [15:0] counterValue,
  output logic [15:0] compareValue,
  output logic countDown,
  output logic counterRun,
  output logic updateEvent
);
  import cpoc_pkg::*;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [15:0] autoReloadValue;
  logic tin_q, trigEdge;
  assign trigEdge = timerInputPin && !tin_q;

  cpoc_counter cpoc_counter_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .cntCfg(cntCfg),
    .dirSw(dirSw),
    .autoReloadWrite(autoReloadWrite),
    .autoReloadWrEn(autoReloadWrEn),
    .counterRunSet(counterRunSet),
    .counterRunClr(counterRunClr),
    .updateGenerate(updateGenerate),
    .triggerStart(trigEdge),
    .counterValue(counterValue),
    .autoReloadValue(autoReloadValue),
    .countDown(countDown),
    .counterRun(counterRun),
    .updateEvent(updateEvent)
  );

  // ----------------------------------------
  // Compare preload and shadow
  // ----------------------------------------
  logic [15:0] pre_q, shadow_q;
  logic hiPending_q;
  wire logic [15:0] preNext = compareHighWrite ? {compareByteData, pre_q[7:0]} :
                              compareLowWrite ? {pre_q[15:8], compareByteData} : pre_q;
  // Upper byte first; shadow stays frozen until the lower byte lands
  wire logic shadowBlocked = (hiPending_q && !compareLowWrite) || compareHighWrite;
  wire logic shadowLoad = !shadowBlocked &&
                          (!chanCfg.comparePreloadEnable || updateEvent);
  wire logic [15:0] shadowNext = shadowLoad ? preNext : shadow_q;
  assign compareValue = pre_q;

  // ----------------------------------------
  // Compare and reference decode
  // ----------------------------------------
  wire logic isOutput = (chanCfg.channelDirectionSelect == `CPOC_DIR_OUTPUT);
  wire logic [2:0] mode = chanCfg.compareModeField;
  wire logic isPwm = (mode == `CPOC_MODE_PWM1) || (mode == `CPOC_MODE_PWM2);
  wire logic edgeMode = (cntCfg.centerAlignSelect == `CPOC_CMS_EDGE);
  wire logic match = (counterValue == shadow_q);
  // Flag direction qualifier for center-aligned counting
  wire logic flagDirOk = edgeMode ||
    (cntCfg.centerAlignSelect == `CPOC_CMS_BOTH) ||
    (cntCfg.centerAlignSelect == `CPOC_CMS_DOWN && countDown) ||
    (cntCfg.centerAlignSelect == `CPOC_CMS_UP && !countDown);

  // PWM mode 1 level; compare above reload holds high, zero compare up holds low
  wire logic pwm1Up = (counterValue < shadow_q);
  wire logic pwm1Dn = !(counterValue > shadow_q);
  wire logic pwm1 = (shadow_q > autoReloadValue) ? 1'b1 : (countDown ? pwm1Dn : pwm1Up);
  wire logic pwmLevel = (mode == `CPOC_MODE_PWM2) ? !pwm1 : pwm1;
  // Level a match would give: the active phase of a one-pulse waveform
  wire logic fastLevel = (mode == `CPOC_MODE_PWM2) ? !countDown : countDown;

  logic ref_q, ref_d, matchHit_q, flag_q, fastHold_q;
  // Fast start holds the match level to the period end; the comparison alone
  // would pull the reference straight back on the next count
  wire logic fastHoldNext = isPwm && chanCfg.fastOutputEnable &&
                            (trigEdge || (fastHold_q && !updateEvent));

  always_comb begin
    ref_d = ref_q;
    if (isOutput) begin
      unique case (mode)
        `CPOC_MODE_FORCE_HI: ref_d = 1'b1;
        `CPOC_MODE_FORCE_LO: ref_d = 1'b0;
        `CPOC_MODE_PWM1, `CPOC_MODE_PWM2: begin
          ref_d = pwmLevel;
          if (chanCfg.fastOutputEnable && (trigEdge || fastHold_q)) begin
            ref_d = fastLevel;
          end
        end
        // Compare modes act on the registered match, never on update events
        `CPOC_MODE_SET_ACT: if (matchHit_q) ref_d = 1'b1;
        `CPOC_MODE_SET_INACT: if (matchHit_q) ref_d = 1'b0;
        `CPOC_MODE_TOGGLE: if (matchHit_q) ref_d = !ref_q;
        `CPOC_MODE_FROZEN: ref_d = ref_q;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_q <= `CPOC_RESET_WORD;
      shadow_q <= `CPOC_RESET_WORD;
      hiPending_q <= 1'b0;
      tin_q <= 1'b0;
      ref_q <= 1'b0;
      matchHit_q <= 1'b0;
      flag_q <= 1'b0;
      fastHold_q <= 1'b0;
    end else begin
      pre_q <= preNext;
      fastHold_q <= fastHoldNext;
      shadow_q <= shadowNext;
      hiPending_q <= compareHighWrite ? 1'b1 : (compareLowWrite ? 1'b0 : hiPending_q);
      tin_q <= timerInputPin;
      // One-cycle registered match; flagged even while forced
      matchHit_q <= match && counterRun && flagDirOk;
      ref_q <= ref_d;
      // Set wins over a same-cycle clear
      flag_q <= (match && counterRun && flagDirOk && isOutput) ||
                (flag_q && !matchFlagClear);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign outputReference = ref_q;
  assign channelPinOutput = ref_q ^ chanCfg.outputPolarity;
  assign channelPinOutputEn = chanCfg.channelOutputEnable && mainOutputGate && isOutput;
  assign channelMatchFlag = flag_q;
  assign channelIrq = flag_q && chanCfg.channelIrqEnable;
endmodule

//--- sim/cpoc_load_model.sv
// Load model: the level an external driver stage sees on the channel pin
`timescale 1ns/1ps
module cpoc_load_model (
  input wire logic channelPinOutput,
  input wire logic channelPinOutputEn,
  output logic loadLevel
);
  // A released pin is pulled low, so a stale level never passes for a driven one
  assign loadLevel = channelPinOutputEn ? channelPinOutput : 1'h0;
endmodule

//--- sim/cpoc_channel_sva.sv
// Checker for the compare PWM output channel
`timescale 1ns/1ps
`include "cpoc_consts.svh"
module cpoc_channel_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire cpoc_pkg::cpoc_chan_cfg_t chanCfg,
  input wire cpoc_pkg::cpoc_cnt_cfg_t cntCfg,
  input wire logic channelPinOutput,
  input wire logic outputReference,
  input wire logic channelMatchFlag,
  input wire logic channelIrq,
  input wire logic [15:0] counterValue,
  input wire logic [15:0] compareValue,
  input wire logic countDown,
  input wire logic counterRun,
  input wire logic updateEvent
);
  import cpoc_pkg::*;
  logic [2:0] mode;
  logic isOut;
  logic dirOk;
  assign mode = chanCfg.compareModeField;
  assign isOut = chanCfg.channelDirectionSelect == `CPOC_DIR_OUTPUT;
  // Center-aligned counting flags only the selected count direction
  assign dirOk = (cntCfg.centerAlignSelect == `CPOC_CMS_EDGE) ||
    (cntCfg.centerAlignSelect == `CPOC_CMS_BOTH) ||
    (cntCfg.centerAlignSelect == `CPOC_CMS_DOWN && countDown) ||
    (cntCfg.centerAlignSelect == `CPOC_CMS_UP && !countDown);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Only with preload off is the visible compare word the live shadow
  sequence s_hit;
    isOut && counterRun && dirOk && !chanCfg.comparePreloadEnable &&
      counterValue == compareValue;
  endsequence
  a_pin_polarity:
    assert property (channelPinOutput == (outputReference ^ chanCfg.outputPolarity))
    else $error("pin polarity wrong");
  a_force_high:
    assert property (isOut && mode == `CPOC_MODE_FORCE_HI |=> outputReference)
    else $error("force high lost");
  a_force_low:
    assert property (isOut && mode == `CPOC_MODE_FORCE_LO |=> !outputReference)
    else $error("force low lost");
  a_match_flag:
    assert property (s_hit |=> channelMatchFlag)
    else $error("flag missing");
  a_irq_gate:
    assert property (channelIrq == (channelMatchFlag && chanCfg.channelIrqEnable))
    else $error("irq gate wrong");
  a_match_active:
    assert property (s_hit ##0 mode == `CPOC_MODE_SET_ACT |-> ##2 outputReference)
    else $error("set active missed");
  a_match_toggle:
    assert property (s_hit ##0 mode == `CPOC_MODE_TOGGLE
      |-> ##2 outputReference != $past(outputReference))
    else $error("toggle missed");
  a_single_stop:
    assert property (cntCfg.singlePulseEnable && updateEvent && counterRun |=> !counterRun)
    else $error("one-pulse did not stop");
endmodule

//--- sim/cpoc_channel_bench.sv
// Self-checking bench for the compare PWM output channel
`timescale 1ns/1ps
`include "cpoc_consts.svh"
module cpoc_channel_bench;
  import cpoc_pkg::*;
  logic clk_sys = 1'h0, rst = 1'h1, dirSw = 1'h0, timerInputPin = 1'h0, mainOutputGate = 1'h1;
  logic [6:0] stb = 7'h00;
  logic [7:0] compareByteData = 8'h00;
  logic [15:0] autoReloadWrite = 16'h0000;
  cpoc_chan_cfg_t chanCfg = 10'h083;
  cpoc_cnt_cfg_t cntCfg = 10'h000;
  logic compareHighWrite, compareLowWrite, autoReloadWrEn, counterRunSet, counterRunClr;
  logic updateGenerate, matchFlagClear, channelPinOutput, channelPinOutputEn, outputReference;
  logic channelMatchFlag, channelIrq, countDown, counterRun, updateEvent, loadLevel;
  logic [15:0] counterValue, compareValue, cv;
  int n_fail = 0, comparisons = 0;
  // One vector for all strobes keeps every pulse exactly one cycle wide
  assign {matchFlagClear, updateGenerate, counterRunClr, counterRunSet, autoReloadWrEn,
    compareLowWrite, compareHighWrite} = stb;
  cpoc_channel cpoc_channel_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .chanCfg(chanCfg),
    .cntCfg(cntCfg),
    .dirSw(dirSw),
    .compareByteData(compareByteData),
    .compareHighWrite(compareHighWrite),
    .compareLowWrite(compareLowWrite),
    .autoReloadWrite(autoReloadWrite),
    .autoReloadWrEn(autoReloadWrEn),
    .counterRunSet(counterRunSet),
    .counterRunClr(counterRunClr),
    .updateGenerate(updateGenerate),
    .timerInputPin(timerInputPin),
    .mainOutputGate(mainOutputGate),
    .matchFlagClear(matchFlagClear),
    .channelPinOutput(channelPinOutput),
    .channelPinOutputEn(channelPinOutputEn),
    .outputReference(outputReference),
    .channelMatchFlag(channelMatchFlag),
    .channelIrq(channelIrq),
    .counterValue(counterValue),
    .compareValue(compareValue),
    .countDown(countDown),
    .counterRun(counterRun),
    .updateEvent(updateEvent)
  );
  cpoc_load_model cpoc_load_model_i (.channelPinOutput, .channelPinOutputEn, .loadLevel);
  task automatic chk(input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys);
    stb <= 7'h01 << k;
    @(posedge clk_sys);
    stb <= 7'h00;
  endtask
  task automatic setMode(input logic [2:0] m);
    @(posedge clk_sys);
    chanCfg.compareModeField <= m;
  endtask
  // Stop, load reload and compare (upper byte first), then update
  task automatic setup(input logic [15:0] auto_reload_value, cmp);
    pulse(4);
    @(posedge clk_sys);
    autoReloadWrite <= auto_reload_value;
    compareByteData <= cmp[15:8];
    stb <= 7'h05;
    @(posedge clk_sys);
    compareByteData <= cmp[7:0];
    stb <= 7'h02;
    @(posedge clk_sys);
    stb <= 7'h20;
    @(posedge clk_sys);
    stb <= 7'h00;
  endtask
  task automatic t_force();
    setup(16'h0009, 16'h0005);
    tick(1);
    chk(compareValue, 16'h0005);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_sys);
      chanCfg.outputPolarity <= p[0];
      chanCfg.compareModeField <= `CPOC_MODE_FORCE_HI;
      tick(2);
      chk(outputReference, 16'h0001);
      chk(loadLevel, !p[0]);
      setMode(`CPOC_MODE_FORCE_LO);
      tick(2);
      chk(channelPinOutput, p[0]);
    end
    pulse(3);
    tick(12);
    chk({channelMatchFlag, channelIrq, outputReference}, 16'h0006);
    @(posedge clk_sys);
    mainOutputGate <= 1'h0;
    chanCfg.channelDirectionSelect <= 2'h1;
    chanCfg.compareModeField <= `CPOC_MODE_FORCE_HI;
    tick(2);
    chk({channelPinOutputEn, outputReference}, 16'h0000);
    setMode(`CPOC_MODE_FORCE_LO);
    @(posedge clk_sys);
    mainOutputGate <= 1'h1;
    chanCfg.channelDirectionSelect <= 2'h0;
    tick(1);
    chk(channelPinOutputEn, 16'h0001);
  endtask
  task automatic t_oc();
    for (int i = 0; i < 4; i++) begin
      setup(16'h0009, 16'h0005);
      setMode((i == 0 || i == 2) ? `CPOC_MODE_FORCE_HI : `CPOC_MODE_FORCE_LO);
      pulse(6);
      setMode(3'(i));
      pulse(3);
      for (int k = 0; k < 30 && channelMatchFlag !== 1'h1; k++) tick(1);
      tick(1);
      chk(outputReference, i != 2);
      pulse(5);
      tick(1);
      chk(outputReference, i != 2);
    end
  endtask
  task automatic t_pwm();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      chanCfg.comparePreloadEnable <= 1'h1;
      chanCfg.compareModeField <= i[0] ? `CPOC_MODE_PWM2 : `CPOC_MODE_PWM1;
      dirSw <= i[1];
      setup(16'h0009, 16'h0004);
      pulse(3);
      tick(1);
      repeat (24) begin
        cv = counterValue;
        tick(1);
        chk(outputReference, (i[1] ? cv <= 4 : cv < 4) ^ i[0]);
      end
      chk(countDown, i[1]);
    end
  endtask
  task automatic t_opm();
    @(posedge clk_sys);
    dirSw <= 1'h0;
    cntCfg <= {`CPOC_CMS_EDGE, 2'h2, `CPOC_TRIG_SEL_INPUT, `CPOC_SLAVE_TRIGGER};
    chanCfg.compareModeField <= `CPOC_MODE_PWM2;
    for (int f = 0; f < 2; f++) begin
      @(posedge clk_sys);
      chanCfg.fastOutputEnable <= f[0];
      setup(16'h001E, 16'h0014);
      @(posedge clk_sys);
      timerInputPin <= 1'h1;
      tick(4);
      chk({counterRun, outputReference}, {1'h1, f[0]});
      for (int k = 0; k < 60 && counterRun === 1'h1; k++) tick(1);
      chk(counterRun, 16'h0000);
      chk(counterValue, 16'h0000);
      @(posedge clk_sys);
      timerInputPin <= 1'h0;
    end
  endtask
  // Center-aligned: compare 3 is met once counting up, then once counting down
  task automatic t_center();
    for (int c = 1; c < 4; c++) begin
      @(posedge clk_sys);
      cntCfg <= {c[1:0], 8'h00};
      setup(16'h0008, 16'h0003);
      pulse(6);
      pulse(3);
      tick(8);
      chk(countDown, 16'h0001);
      chk(channelMatchFlag, c != 1);
      pulse(6);
      tick(8);
      chk(channelMatchFlag, c != 2);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // Whole run is under two thousand cycles; this margin only catches hangs
  initial begin
    #40000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    t_force();
    t_oc();
    t_pwm();
    t_opm();
    t_center();
    close_out();
  end
endmodule
bind cpoc_channel cpoc_channel_sva cpoc_channel_sva_i (.clk_sys, .rst, .chanCfg, .cntCfg,
  .channelPinOutput, .outputReference, .channelMatchFlag, .channelIrq, .counterValue,
  .compareValue, .countDown, .counterRun, .updateEvent);
